// >>> design/core_exec_pkg.sv
// Shared constants, types and helpers for the instruction subset core
// Functional notes
// (RQ1) Skip-test reads file; bit zero runs next normally
// (RQ2) Bit one flushes next fetch, two cycles
// (RQ3) Call pushes next instruction address onto stack
// (RQ4) Call loads eleven-bit immediate into PC low bits
// (RQ5) Call copies high latch bits 4:3 to PC
// (RQ6) Call takes two cycles, second is no-op
// (RQ7) OR combines accumulator with file register
// (RQ8) OR destination bit selects accumulator or file
// (RQ9) Move copies file to accumulator or back
// (RQ10) Move updates zero flag from moved value
// (RQ11) Four phases per instruction cycle
// (RQ12) Operand read Q2, destination write Q4
// (RQ13) Zero flag set when result is zero
// (RQ14) Stack push in Q2, PC update in Q4
package core_exec_pkg;

	// Widths of the datapath
	localparam int PC_W    = 13;
	localparam int INSTR_W = 14;
	localparam int DATA_W  = 8;
	localparam int FADDR_W = 7;
	localparam int CALLK_W = 11;
	localparam int HL_W    = 5;
	localparam int REGA_W  = 3;

	// Opcode prefixes
	localparam logic [3:0] OPC_SKIP_ONE = 4'h7;  // 01 11
	localparam logic [2:0] OPC_CALL     = 3'h4;  // 10 0
	localparam logic [5:0] OPC_OR_ACC   = 6'h04; // 00 0100
	localparam logic [5:0] OPC_MOVE     = 6'h08; // 00 1000

	// Field positions
	localparam int DEST_BIT = 7;
	localparam int BSEL_LSB = 7;
	localparam int HL_LO    = 3;
	localparam int HL_HI    = 4;

	// Register offsets on the plain register port
	localparam logic [REGA_W-1:0] REG_ACC     = 3'h0;
	localparam logic [REGA_W-1:0] REG_STATUS  = 3'h1;
	localparam logic [REGA_W-1:0] REG_HIGHLAT = 3'h2;
	localparam logic [REGA_W-1:0] REG_PC_LOW  = 3'h3;
	localparam logic [REGA_W-1:0] REG_PC_HIGH = 3'h4;
	localparam logic [REGA_W-1:0] REG_EXEC    = 3'h5;

	// Status register field positions
	localparam int ST_ZERO = 0;
	localparam int ST_SKIP = 1;

	// Values after reset
	localparam logic [PC_W-1:0]    PC_RST    = 13'h0000;
	localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;
	localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
	localparam logic [HL_W-1:0]    HL_RST    = 5'h00;

	// Instruction cycle phases
	typedef enum logic [3:0] {
		PH_Q1 = 4'h1,
		PH_Q2 = 4'h2,
		PH_Q3 = 4'h4,
		PH_Q4 = 4'h8
	} phase_e;

	// Decoded instruction kinds
	typedef enum logic [4:0] {
		K_NOP  = 5'h01,
		K_SKIP = 5'h02,
		K_CALL = 5'h04,
		K_OR   = 5'h08,
		K_MOVE = 5'h10
	} kind_e;

	// Zero test of an eight-bit result
	function automatic logic isZero(input logic [DATA_W-1:0] v);
		return (v == 8'h00);
	endfunction : isZero

	// Next sequential program address
	function automatic logic [PC_W-1:0] pcNext(input logic [PC_W-1:0] pc);
		return pc + 13'h0001;
	endfunction : pcNext

endpackage : core_exec_pkg

// >>> design/core_instruction_subset_exec.sv
// Execution core for skip-test, call, OR and move-file instructions
`timescale 1ns/1ps
module core_instruction_subset_exec (
	input  wire logic                              mclk,
	input  wire logic                              rst_n,
	input  wire logic                              clkEn,
	output logic [core_exec_pkg::PC_W-1:0]         progAddr,
	input  wire logic [core_exec_pkg::INSTR_W-1:0] progData,
	output logic [core_exec_pkg::FADDR_W-1:0]      fileAddr,
	output logic                                   fileRdEn,
	input  wire logic [core_exec_pkg::DATA_W-1:0]  fileRdData,
	output logic                                   fileWrEn,
	output logic [core_exec_pkg::DATA_W-1:0]       fileWrData,
	output logic                                   stackPush,
	output logic [core_exec_pkg::PC_W-1:0]         returnStackTop,
	output logic [3:0]                             phase,
	input  wire logic [core_exec_pkg::REGA_W-1:0]  regAddr,
	input  wire logic [core_exec_pkg::DATA_W-1:0]  regWrData,
	input  wire logic                              regWr,
	input  wire logic                              regRd,
	output logic [core_exec_pkg::DATA_W-1:0]       regRdData
);

	// Phase sequencer and pipeline state
	core_exec_pkg::phase_e             phase_r;
	logic [core_exec_pkg::INSTR_W-1:0] instr_r;
	logic                              execNop_r;
	logic [core_exec_pkg::PC_W-1:0]    pc_r;

	// Datapath state
	logic [core_exec_pkg::DATA_W-1:0]  operand_r;
	logic [core_exec_pkg::DATA_W-1:0]  result_r;
	logic [core_exec_pkg::DATA_W-1:0]  acc_r;
	logic                              zero_r;
	logic                              skipTaken_r;
	logic [core_exec_pkg::HL_W-1:0]    highLatch_r;

	// Port-facing registers
	logic [core_exec_pkg::FADDR_W-1:0] fileAddr_r;
	logic                              fileRdEn_r;
	logic                              fileWrEn_r;
	logic [core_exec_pkg::DATA_W-1:0]  fileWrData_r;
	logic                              stackPush_r;
	logic [core_exec_pkg::PC_W-1:0]    stackTop_r;
	logic [core_exec_pkg::DATA_W-1:0]  regRdData_r;

	// Cleared data word, declared ahead of every process that uses it
	localparam logic [core_exec_pkg::DATA_W-1:0] ACC_ZERO = core_exec_pkg::ACC_RST;

	// Decode results
	core_exec_pkg::kind_e              kind;
	logic                              readsFile;
	logic                              writesResult;
	logic [core_exec_pkg::DATA_W-1:0]  result_nxt;
	logic [core_exec_pkg::PC_W-1:0]    callTarget;
	logic                              testBit;

	decode_if dec ();

	opcode_decode u_decode (
		.dec (dec)
	);

	assign dec.instr = instr_r;

	// A flushed cycle executes as a no-op whatever sits in the instruction register
	assign kind = execNop_r ? core_exec_pkg::K_NOP : dec.kind; // RQ2 RQ6

	// Instructions that touch the file register operand
	assign readsFile = (kind == core_exec_pkg::K_SKIP) ||
	                   (kind == core_exec_pkg::K_OR) ||
	                   (kind == core_exec_pkg::K_MOVE);

	// OR and move produce a result that goes to a destination
	assign writesResult = (kind == core_exec_pkg::K_OR) || (kind == core_exec_pkg::K_MOVE);

	// Result of the processing phase
	always_comb begin
		result_nxt = operand_r; // RQ9
		if (kind == core_exec_pkg::K_OR) begin
			result_nxt = acc_r | operand_r; // RQ7
		end
	end

	// Call destination: latch bits on top, immediate below
	assign callTarget = {highLatch_r[core_exec_pkg::HL_HI:core_exec_pkg::HL_LO], // RQ5
	                     dec.target}; // RQ4

	// Selected bit of the operand for the skip test
	assign testBit = operand_r[dec.bitSel]; // RQ1

	// Quadrature phase counter, one instruction cycle every four clocks
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			phase_r <= core_exec_pkg::PH_Q1;
		end else if (clkEn) begin
			unique case (phase_r)
				core_exec_pkg::PH_Q1: phase_r <= core_exec_pkg::PH_Q2; // RQ11
				core_exec_pkg::PH_Q2: phase_r <= core_exec_pkg::PH_Q3; // RQ11
				core_exec_pkg::PH_Q3: phase_r <= core_exec_pkg::PH_Q4; // RQ11
				core_exec_pkg::PH_Q4: phase_r <= core_exec_pkg::PH_Q1; // RQ11
			endcase
		end
	end

	// Fetch: the instruction at the current address is latched at the end of Q4
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			instr_r <= core_exec_pkg::INSTR_RST;
		end else if (clkEn && phase_r == core_exec_pkg::PH_Q4) begin
			instr_r <= progData;
		end
	end

	// Flush marker: the fetched word is discarded after a call or a taken skip
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			execNop_r <= 1'b1; // Nothing valid fetched yet
		end else if (clkEn && phase_r == core_exec_pkg::PH_Q4) begin
			execNop_r <= (kind == core_exec_pkg::K_CALL) || // RQ6
			             skipTaken_r; // RQ2
		end
	end

	// Program counter: sequential step or call target, changed only in Q4
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pc_r <= core_exec_pkg::PC_RST;
		end else if (clkEn && phase_r == core_exec_pkg::PH_Q4) begin
			if (kind == core_exec_pkg::K_CALL) begin
				pc_r <= callTarget; // RQ4 RQ5 RQ14
			end else begin
				pc_r <= core_exec_pkg::pcNext(pc_r);
			end
		end
	end

	// Return stack push during Q2 of the call's first cycle
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			stackPush_r <= 1'b0;
			stackTop_r  <= core_exec_pkg::PC_RST;
		end else if (clkEn) begin
			stackPush_r <= 1'b0;
			if (phase_r == core_exec_pkg::PH_Q1 && kind == core_exec_pkg::K_CALL) begin
				stackPush_r <= 1'b1; // RQ14
				stackTop_r  <= pc_r; // RQ3
			end
		end
	end

	// File read request stands through Q2
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fileRdEn_r <= 1'b0;
			fileAddr_r <= '0;
		end else if (clkEn) begin
			fileRdEn_r <= 1'b0;
			if (phase_r == core_exec_pkg::PH_Q1 && readsFile) begin
				fileRdEn_r <= 1'b1; // RQ12
				fileAddr_r <= dec.fileSel;
			end
		end
	end

	// Operand captured at the end of Q2
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			operand_r <= ACC_ZERO;
		end else if (clkEn && phase_r == core_exec_pkg::PH_Q2 && readsFile) begin
			operand_r <= fileRdData; // RQ12
		end
	end

	// Processing in Q3: result and skip decision
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			result_r    <= ACC_ZERO;
			skipTaken_r <= 1'b0;
		end else if (clkEn) begin
			if (phase_r == core_exec_pkg::PH_Q3) begin
				result_r    <= result_nxt;
				skipTaken_r <= (kind == core_exec_pkg::K_SKIP) && testBit; // RQ1 RQ2
			end else if (phase_r == core_exec_pkg::PH_Q4) begin
				skipTaken_r <= 1'b0;
			end
		end
	end

	// File write strobe stands through Q4 when the destination bit is one
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fileWrEn_r   <= 1'b0;
			fileWrData_r <= ACC_ZERO;
		end else if (clkEn) begin
			fileWrEn_r <= 1'b0;
			if (phase_r == core_exec_pkg::PH_Q3 && writesResult && dec.destFile) begin
				fileWrEn_r   <= 1'b1; // RQ8 RQ9 RQ12
				fileWrData_r <= result_nxt;
			end
		end
	end

	// Accumulator: execution write at end of Q4 wins over a software write
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			acc_r <= core_exec_pkg::ACC_RST;
		end else if (clkEn) begin
			if (phase_r == core_exec_pkg::PH_Q4 && writesResult && !dec.destFile) begin
				acc_r <= result_r; // RQ8 RQ9 RQ12
			end else if (regWr && regAddr == core_exec_pkg::REG_ACC) begin
				acc_r <= regWrData;
			end
		end
	end

	// Zero flag follows OR and move results; hardware update beats software
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			zero_r <= 1'b0;
		end else if (clkEn) begin
			if (phase_r == core_exec_pkg::PH_Q4 && writesResult) begin
				zero_r <= core_exec_pkg::isZero(result_r); // RQ10 RQ13
			end else if (regWr && regAddr == core_exec_pkg::REG_STATUS) begin
				zero_r <= regWrData[core_exec_pkg::ST_ZERO];
			end
		end
	end

	// Program-counter high latch, written by software only
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			highLatch_r <= core_exec_pkg::HL_RST;
		end else if (clkEn && regWr && regAddr == core_exec_pkg::REG_HIGHLAT) begin
			highLatch_r <= regWrData[core_exec_pkg::HL_W-1:0];
		end
	end

	// Register read port: data stands in the cycle after the strobe only
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			regRdData_r <= ACC_ZERO;
		end else if (clkEn) begin
			regRdData_r <= ACC_ZERO;
			if (regRd) begin
				unique case (regAddr)
					core_exec_pkg::REG_ACC:     regRdData_r <= acc_r;
					core_exec_pkg::REG_STATUS:  regRdData_r <= {6'h00, skipTaken_r, zero_r};
					core_exec_pkg::REG_HIGHLAT: regRdData_r <= {3'h0, highLatch_r};
					core_exec_pkg::REG_PC_LOW:  regRdData_r <= pc_r[7:0];
					core_exec_pkg::REG_PC_HIGH: regRdData_r <= {3'h0, pc_r[12:8]};
					core_exec_pkg::REG_EXEC:    regRdData_r <= {3'h0, kind};
					default:                    regRdData_r <= ACC_ZERO;
				endcase
			end
		end
	end

	// Outputs straight from flip-flops
	assign progAddr       = pc_r;
	assign fileAddr       = fileAddr_r;
	assign fileRdEn       = fileRdEn_r;
	assign fileWrEn       = fileWrEn_r;
	assign fileWrData     = fileWrData_r;
	assign stackPush      = stackPush_r;
	assign returnStackTop = stackTop_r;
	assign phase          = phase_r;
	assign regRdData      = regRdData_r;

endmodule : core_instruction_subset_exec

// >>> design/decode_if.sv
// Decode carrier between the execution core and the opcode decoder
`timescale 1ns/1ps
interface decode_if;
	logic [core_exec_pkg::INSTR_W-1:0] instr;
	core_exec_pkg::kind_e              kind;
	logic [core_exec_pkg::FADDR_W-1:0] fileSel;
	logic                              destFile;
	logic [2:0]                        bitSel;
	logic [core_exec_pkg::CALLK_W-1:0] target;

	modport decoder (input instr, output kind, fileSel, destFile, bitSel, target);
	modport core    (output instr, input kind, fileSel, destFile, bitSel, target);
endinterface : decode_if

// >>> design/opcode_decode.sv
// Opcode decoder for the four supported instructions
`timescale 1ns/1ps
module opcode_decode (
	decode_if.decoder dec
);

	// Pattern match on the opcode prefixes; anything else is a no-op
	always_comb begin
		dec.kind = core_exec_pkg::K_NOP;
		if (dec.instr[13:10] == core_exec_pkg::OPC_SKIP_ONE) begin
			dec.kind = core_exec_pkg::K_SKIP; // RQ1
		end else if (dec.instr[13:11] == core_exec_pkg::OPC_CALL) begin
			dec.kind = core_exec_pkg::K_CALL; // RQ4
		end else if (dec.instr[13:8] == core_exec_pkg::OPC_OR_ACC) begin
			dec.kind = core_exec_pkg::K_OR; // RQ7
		end else if (dec.instr[13:8] == core_exec_pkg::OPC_MOVE) begin
			dec.kind = core_exec_pkg::K_MOVE; // RQ9
		end
	end

	// Operand fields
	assign dec.fileSel  = dec.instr[core_exec_pkg::FADDR_W-1:0];
	assign dec.destFile = dec.instr[core_exec_pkg::DEST_BIT];
	assign dec.bitSel   = dec.instr[core_exec_pkg::BSEL_LSB+2:core_exec_pkg::BSEL_LSB];
	assign dec.target   = dec.instr[core_exec_pkg::CALLK_W-1:0];

endmodule : opcode_decode

// >>> verification/core_exec_monitor.sv
// Checker for phase timing, call, skip and move behaviour of the core
`timescale 1ns/1ps
module core_exec_monitor (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        clkEn,
	input wire logic [12:0] progAddr,
	input wire logic [13:0] progData,
	input wire logic        fileRdEn,
	input wire logic [7:0]  fileRdData,
	input wire logic        fileWrEn,
	input wire logic [7:0]  fileWrData,
	input wire logic        stackPush,
	input wire logic [12:0] returnStackTop,
	input wire logic [3:0]  phase,
	input wire logic [2:0]  regAddr,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [7:0]  regWrData,
	input wire logic [7:0]  regRdData
);
	logic [13:0] instr_r;
	logic [4:0]  hl_r;

	// Track the executing word and the high latch contents
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			instr_r <= 14'h0000;
			hl_r    <= 5'h00;
		end else if (clkEn) begin
			if (phase == 4'h8)
				instr_r <= progData;
			if (regWr && regAddr == 3'h2)
				hl_r <= regWrData[4:0];
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	phase_rotate_a: assert property (rst_n && clkEn |=> phase == {$past(phase[2:0]), $past(phase[3])})
		else $error("phase did not rotate");
	freeze_hold_a: assert property (rst_n && !clkEn |=> $stable(phase) && $stable(progAddr))
		else $error("state moved while clock enable low");
	read_phase_a: assert property (fileRdEn |-> phase == 4'h2)
		else $error("file read outside second phase");
	write_phase_a: assert property (fileWrEn |-> phase == 4'h8)
		else $error("file write outside fourth phase");
	push_value_a: assert property (stackPush |-> phase == 4'h2 && returnStackTop == progAddr)
		else $error("push value or phase wrong");
	call_target_a: assert property (stackPush && clkEn ##1 clkEn [*3]
		|-> progAddr == {hl_r[4:3], $past(instr_r[10:0], 3)})
		else $error("call target wrong");
	call_flush_a: assert property (stackPush && clkEn ##1 clkEn [*2]
		|=> (!fileRdEn && !fileWrEn && !stackPush) [*4])
		else $error("call second cycle not idle");
	skip_flush_a: assert property (fileRdEn && clkEn && instr_r[13:10] == 4'h7
		&& fileRdData[instr_r[9:7]] ##1 clkEn [*2]
		|=> (!fileRdEn && !fileWrEn && !stackPush) [*4])
		else $error("skipped cycle not idle");
	move_data_a: assert property (fileWrEn && instr_r[13:8] == 6'h08
		|-> fileWrData == $past(fileRdData, 2))
		else $error("move wrote wrong value");
	hl_read_a: assert property (clkEn && regRd && regAddr == 3'h2 |=> regRdData == {3'h0, hl_r})
		else $error("high latch readback wrong");

	// Main scenarios
	cover property (stackPush && clkEn);
	cover property (fileWrEn && instr_r[13:8] == 6'h08);
	cover property (fileRdEn && instr_r[13:10] == 4'h7 && fileRdData[instr_r[9:7]]);
endmodule : core_exec_monitor

// >>> verification/core_instruction_subset_exec_tb.sv
// Bench running a short program through the instruction core
`timescale 1ns/1ps
module core_instruction_subset_exec_tb;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        clkEn = 1'b1;
	logic [12:0] progAddr;
	logic [13:0] progData;
	logic [6:0]  fileAddr;
	logic        fileRdEn;
	logic [7:0]  fileRdData;
	logic        fileWrEn;
	logic [7:0]  fileWrData;
	logic        stackPush;
	logic [12:0] returnStackTop;
	logic [3:0]  phase;
	logic [2:0]  regAddr = 3'h0;
	logic [7:0]  regWrData = 8'h00;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [7:0]  regRdData;
	int          errors = 0;
	int          n_compared = 0;

	// 50 MHz clock
	always #10 mclk = ~mclk;

	core_instruction_subset_exec i_core_instruction_subset_exec (.mclk, .rst_n, .clkEn,
		.progAddr, .progData, .fileAddr, .fileRdEn, .fileRdData, .fileWrEn, .fileWrData,
		.stackPush, .returnStackTop, .phase, .regAddr, .regWrData, .regWr, .regRd, .regRdData);
	prog_file_model i_prog_file_model (.mclk, .clkEn, .progAddr, .progData, .fileAddr,
		.fileRdEn, .fileRdData, .fileWrEn, .fileWrData, .stackPush, .returnStackTop);

	// Compare one result
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			errors++;
		end
	endtask : check_val

	// One-cycle register write
	task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
		regAddr   <= a;
		regWrData <= d;
		regWr     <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : reg_write

	// Register read, data taken in the following cycle
	task automatic reg_check(input logic [2:0] a, input logic [7:0] exp);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(posedge mclk);
		check_val({8'h00, regRdData}, {8'h00, exp});
	endtask : reg_check

	// Verdict and end of run
	task automatic tally_and_finish;
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	// Program: move, OR to file, self move, taken skip, kept skip, OR, call
	initial begin
		for (int i = 0; i < 8192; i++) begin
			i_prog_file_model.progMem[i] = 14'h0000;
			i_prog_file_model.fileMem[i[6:0]] = 8'h00;
		end
		i_prog_file_model.progMem[0] = {6'h08, 1'b0, 7'h20};
		i_prog_file_model.progMem[1] = {6'h04, 1'b1, 7'h21};
		i_prog_file_model.progMem[2] = {6'h08, 1'b1, 7'h22};
		i_prog_file_model.progMem[3] = {4'h7, 3'h7, 7'h21};
		i_prog_file_model.progMem[4] = {6'h08, 1'b0, 7'h22};
		i_prog_file_model.progMem[5] = {4'h7, 3'h2, 7'h21};
		i_prog_file_model.progMem[6] = {6'h04, 1'b0, 7'h24};
		i_prog_file_model.progMem[7] = {3'h4, 11'h155};
		i_prog_file_model.progMem[13'h1955] = {6'h08, 1'b1, 7'h22};
		i_prog_file_model.fileMem[7'h20] = 8'h91;
		i_prog_file_model.fileMem[7'h21] = 8'h13;
		i_prog_file_model.fileMem[7'h24] = 8'h04;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		clkEn <= 1'b0;
		repeat (3) @(posedge mclk);
		clkEn <= 1'b1;
		reg_write(3'h2, 8'h18);
		reg_check(3'h2, 8'h18);
		repeat (60) @(posedge mclk);
		reg_check(3'h0, 8'h95);
		reg_check(3'h1, 8'h01);
		reg_check(3'h5, 8'h01);
		reg_check(3'h6, 8'h00);
		check_val({8'h00, i_prog_file_model.fileMem[7'h21]}, 16'h0093);
		check_val({8'h00, i_prog_file_model.fileMem[7'h22]}, 16'h0000);
		check_val({3'h0, i_prog_file_model.retStack[0]}, 16'h0008);
		check_val(16'(i_prog_file_model.retStack.size()), 16'h0001);
		reg_write(3'h0, 8'h5a);
		reg_check(3'h0, 8'h5a);
		// Reset in mid-run, then the program runs again with the latch cleared
		rst_n <= 1'b0;
		@(posedge mclk);
		rst_n <= 1'b1;
		reg_check(3'h0, 8'h00);
		reg_check(3'h2, 8'h00);
		repeat (60) @(posedge mclk);
		reg_check(3'h0, 8'h95);
		reg_check(3'h1, 8'h00);
		check_val(16'(i_prog_file_model.retStack.size()), 16'h0002);
		tally_and_finish();
	end

	// Watchdog well beyond the expected run length
	initial begin
		repeat (1000) @(posedge mclk);
		errors++;
		tally_and_finish();
	end
endmodule : core_instruction_subset_exec_tb

bind core_instruction_subset_exec core_exec_monitor i_core_exec_monitor (.mclk, .rst_n, .clkEn,
	.progAddr, .progData, .fileRdEn, .fileRdData, .fileWrEn, .fileWrData, .stackPush,
	.returnStackTop, .phase, .regAddr, .regWr, .regRd, .regWrData, .regRdData);

// >>> verification/prog_file_model.sv
// Program memory, file registers and return stack facing the core
`timescale 1ns/1ps
module prog_file_model (
	input  wire logic        mclk,
	input  wire logic        clkEn,
	input  wire logic [12:0] progAddr,
	output logic      [13:0] progData,
	input  wire logic [6:0]  fileAddr,
	input  wire logic        fileRdEn,
	output logic      [7:0]  fileRdData,
	input  wire logic        fileWrEn,
	input  wire logic [7:0]  fileWrData,
	input  wire logic        stackPush,
	input  wire logic [12:0] returnStackTop
);
	logic [13:0] progMem [0:8191];
	logic [7:0]  fileMem [0:127];
	logic [12:0] retStack [$];

	// Word at the fetch address; read data is junk outside the read phase
	assign progData   = progMem[progAddr];
	assign fileRdData = fileRdEn ? fileMem[fileAddr] : ~fileMem[fileAddr];

	// Destination writes and pushes land on their strobe edge
	always @(posedge mclk) begin
		if (clkEn && fileWrEn)
			fileMem[fileAddr] <= fileWrData;
		if (clkEn && stackPush)
			retStack.push_back(returnStackTop);
	end
endmodule : prog_file_model
